// ### rtl/cgw_watchdog.sv
// Frequency control core: register file, divider latch, watchdog recovery and reset pin.
`timescale 1ns/1ps
module cgw_watchdog
  import cgw_pkg::*;
#(
  parameter int          TICK     = cgw_pkg::TICK_CYC,  // Cycles per second.
  parameter logic [3:0]  REV_ID   = 4'h2,  // Arbitrary revision code.
  parameter logic [3:0]  VENDOR_ID = 4'h5  // Arbitrary vendor code.
)(
  // Clock and reset.
  input  wire logic                 CLOCK_I,
  input  wire logic                 NRST_I,
  // Byte register port.
  input  wire logic [7:0]           REG_ADDR_I,
  input  wire logic                 REG_WR_I,
  input  wire logic [7:0]           REG_WDATA_I,
  input  wire logic                 REG_RD_I,
  output logic      [7:0]           REG_RDATA_O,
  // Shared reset or powerdown pin, open drain when it is an output.
  input  wire logic                 SRST_PIN_I,
  output logic                      SRST_PIN_O,
  output logic                      SRST_PIN_OE_O,
  output logic                      POWERDOWN_O,
  // Frequency selection toward the PLL.
  output logic      [6:0]           PLL_N_O,
  output logic      [5:0]           PLL_R_O,
  output logic                      USE_STRAP_O,
  output logic      [31:0]          PLL_P_O,
  // Spread spectrum selection.
  output logic                      SS_EN_O,
  output logic                      SS_MODE_O,
  output logic      [1:0]           SS_AMT_O
);
  import cgw_pkg::*;

  cgw_wd_if wd ();  // Link to the seconds timer.

  // Software visible state.
  logic [7:0] wdc_r;      // Watchdog register without the alarm bit.
  logic       alarm_r;    // timeout_alarm.
  logic [7:0] n_stage_r;  // pll_n_divider_stage.
  logic [7:0] r_stage_r;  // pll_r_divider_stage.
  logic [7:0] ss_r;       // Spread spectrum control.
  logic       trig_d_r;   // Previous trigger level for edge detection.
  // Applied and remembered frequency settings.
  logic [6:0] n_act_r, n_prev_r;  // Active and second-to-last N.
  logic [5:0] r_act_r, r_prev_r;  // Active and second-to-last R.
  logic       strap_r, strap_prev_r;  // Setting came from the hardware straps.
  // Watchdog sequencing.
  logic       run_r;      // Timer armed.
  logic       seen_r;     // First expiry already taken.
  logic [7:0] pulse_r;    // Remaining reset pulse cycles.
  logic [7:0] rdata_r;
  logic       oe_r, pd_r;

  // Register decode.
  wire wr_wdc = REG_WR_I & (REG_ADDR_I == WATCHDOG_CTRL_OFS);
  wire wr_n   = REG_WR_I & (REG_ADDR_I == N_STAGE_OFS);
  wire wr_r   = REG_WR_I & (REG_ADDR_I == R_STAGE_OFS);
  wire wr_ss  = REG_WR_I & (REG_ADDR_I == SPREAD_CTRL_OFS);

  // Current timeout, after a write in this cycle takes effect.
  wire [3:0] tmo_now  = wr_wdc ? REG_WDATA_I[TMO_LSB +: 4] : wdc_r[TMO_LSB +: 4];
  wire       tmo_off  = (tmo_now == 4'h0);
  wire       latch    = r_stage_r[TRIG_BIT] & ~trig_d_r;
  wire       expire   = wd.expire;
  wire       revert   = expire & seen_r & ~tmo_off;
  wire       to_prev  = wdc_r[REVERT_BIT];
  wire       pin_fn   = wdc_r[PIN_FN_BIT];

  // Reset pulse counter next value and pin enable.
  wire [7:0] pulse_nxt = (expire & ~tmo_off) ? 8'(RST_PULSE_CYC)
                       : ((pulse_r != 8'h00) ? pulse_r - 8'h01 : 8'h00);
  wire       oe_nxt    = (pulse_nxt != 8'h00) & ~pin_fn;

  // Read multiplexer; unmapped offsets read zero.
  wire [7:0] wdc_view = {wdc_r[7:5], alarm_r, wdc_r[3:0]};
  wire [7:0] rd_mux   = (REG_ADDR_I == WATCHDOG_CTRL_OFS) ? wdc_view
                      : (REG_ADDR_I == N_STAGE_OFS)       ? n_stage_r
                      : (REG_ADDR_I == SIGNATURE_OFS)     ? {REV_ID, VENDOR_ID}
                      : (REG_ADDR_I == R_STAGE_OFS)       ? r_stage_r
                      : (REG_ADDR_I == SPREAD_CTRL_OFS)   ? ss_r
                      : 8'h00;

  // Timer control through the interface.
  assign wd.tmo_sel = wdc_r[TMO_LSB +: 4];
  assign wd.run     = run_r & ~tmo_off;
  assign wd.restart = latch;

  cgw_sec_timer #(.TICK(TICK)) u_timer (
    .CLOCK_I (CLOCK_I),
    .NRST_I  (NRST_I),
    .wd      (wd.tmr)
  );

  // Register file writes; the signature has no storage and ignores writes.
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wdc_r     <= WATCHDOG_RST;
      n_stage_r <= N_STAGE_RST;
      r_stage_r <= R_STAGE_RST;
      ss_r      <= SPREAD_RST;
      trig_d_r  <= 1'b0;
    end
    else
    begin
      if (wr_wdc)
      begin
        wdc_r <= {REG_WDATA_I[7:5], 1'b0, REG_WDATA_I[3:0]};
      end
      if (wr_n)
      begin
        n_stage_r <= REG_WDATA_I;
      end
      if (wr_r)
      begin
        r_stage_r <= {1'b0, REG_WDATA_I[6:0]};
      end
      if (wr_ss)
      begin
        ss_r <= {REG_WDATA_I[SS_EN_BIT], 4'h0, REG_WDATA_I[SS_MODE_BIT],
                 REG_WDATA_I[SS_AMT_LSB +: 2]};
      end
      trig_d_r <= r_stage_r[TRIG_BIT];
    end
  end

  // Frequency application: a latch shifts the active pair into history.
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      n_act_r      <= 7'h00;
      r_act_r      <= 6'h00;
      n_prev_r     <= 7'h00;
      r_prev_r     <= 6'h00;
      strap_r      <= 1'b1;
      strap_prev_r <= 1'b1;
    end
    else if (latch)
    begin
      n_prev_r     <= n_act_r;
      r_prev_r     <= r_act_r;
      strap_prev_r <= strap_r;
      n_act_r      <= n_stage_r[6:0];
      r_act_r      <= r_stage_r[R_LSB +: 6];
      strap_r      <= 1'b0;
    end
    else if (revert)
    begin
      n_act_r <= to_prev ? n_prev_r : n_act_r;
      r_act_r <= to_prev ? r_prev_r : r_act_r;
      strap_r <= to_prev ? strap_prev_r : 1'b1;
    end
  end

  // Watchdog sequencing; an expiry in the clearing cycle still sets the alarm.
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      run_r   <= 1'b0;
      seen_r  <= 1'b0;
      alarm_r <= 1'b0;
      pulse_r <= 8'h00;
    end
    else
    begin
      run_r   <= ~tmo_off & (run_r | latch);
      seen_r  <= ~tmo_off & ~latch & (seen_r | expire);
      alarm_r <= expire | (alarm_r & ~tmo_off);
      pulse_r <= pulse_nxt;
    end
  end

  // Output flops for the pin enable, the powerdown output and the read port.
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      oe_r    <= 1'b0;
      pd_r    <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      oe_r    <= oe_nxt;
      pd_r    <= pin_fn & ~SRST_PIN_I;
      rdata_r <= REG_RD_I ? rd_mux : rdata_r;
    end
  end

  assign REG_RDATA_O   = rdata_r;
  assign SRST_PIN_O    = 1'b0 & oe_r;
  assign SRST_PIN_OE_O = oe_r;
  assign POWERDOWN_O   = pd_r;
  assign PLL_N_O       = n_act_r;
  assign PLL_R_O       = r_act_r;
  assign USE_STRAP_O   = strap_r;
  assign PLL_P_O       = PLL_CONST;
  assign SS_EN_O       = ss_r[SS_EN_BIT];
  assign SS_MODE_O     = ss_r[SS_MODE_BIT];
  assign SS_AMT_O      = ss_r[SS_AMT_LSB +: 2];

  // Checks on the sequencing.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  localparam int PW = RST_PULSE_CYC;

  sequence s_expire_armed;
    expire && !tmo_off;
  endsequence
  sequence s_pulse_on;
    oe_r || pin_fn;
  endsequence

  a_alarm_on_expire: assert property (s_expire_armed |=> alarm_r)
    else $error("alarm not set after expiry");
  a_pulse_follows: assert property (s_expire_armed ##1 !pin_fn |-> s_pulse_on [*8])
    else $error("reset pulse missing after expiry");
  a_pulse_width: assert property ($rose(oe_r) && !expire |-> ##(PW - 1) oe_r ##1 !oe_r)
    else $error("reset pulse width wrong");
  a_zero_stops: assert property (wr_wdc && REG_WDATA_I[3:0] == 4'h0 && !expire
                                 |=> !alarm_r && !run_r)
    else $error("zero timeout did not stop watchdog");
  a_latch_copies: assert property (latch |=> PLL_N_O == $past(n_stage_r[6:0])
                                   && PLL_R_O == $past(r_stage_r[6:1]))
    else $error("dividers not latched on edge");
  a_level_holds: assert property (!latch && !revert |=> $stable(PLL_N_O))
    else $error("divider changed without edge");
  a_start_after: assert property (latch && !tmo_off |=> run_r && !strap_r)
    else $error("timer not started after change");
  a_revert_strap: assert property (revert && !to_prev |=> USE_STRAP_O)
    else $error("no strap revert on second expiry");
  // A pin that was already an input one cycle ago must not be driven at all.
  a_pin_powerdown: assert property (pin_fn && $past(pin_fn) |-> !SRST_PIN_OE_O)
    else $error("pin driven while powerdown input");
  a_signature_ro: assert property (REG_RD_I && REG_ADDR_I == SIGNATURE_OFS
                                   |=> REG_RDATA_O == {REV_ID, VENDOR_ID})
    else $error("signature read wrong");

endmodule // cgw_watchdog

// ### rtl/cgw_pkg.sv
// Package of register offsets, field positions, reset values and timing counts for the watchdog.
package cgw_pkg;

  // Register offsets on the byte register port.
  localparam logic [7:0] SPREAD_CTRL_OFS   = 8'h01;  // Spread spectrum control.
  localparam logic [7:0] WATCHDOG_CTRL_OFS = 8'h06;  // Watchdog and pin function control.
  localparam logic [7:0] N_STAGE_OFS       = 8'h07;  // pll_n_divider_stage.
  localparam logic [7:0] SIGNATURE_OFS     = 8'h08;  // silicon_signature.
  localparam logic [7:0] R_STAGE_OFS       = 8'h09;  // pll_r_divider_stage.

  // Field positions of the spread spectrum control register.
  localparam int SS_EN_BIT   = 7;  // Spreading enable.
  localparam int SS_MODE_BIT = 2;  // 0 selects down spread, 1 centre spread.
  localparam int SS_AMT_LSB  = 0;  // Two-bit spread_amount_sel.

  // Field positions of the watchdog control register.
  localparam int PIN_FN_BIT  = 7;  // 1 makes the shared pin powerdown_in.
  localparam int REVERT_BIT  = 6;  // revert_choice.
  localparam int WD_TEST_BIT_BIT  = 5;  // wd_test_bit.
  localparam int ALARM_BIT   = 4;  // timeout_alarm, read only.
  localparam int TMO_LSB     = 0;  // Four-bit timeout_sel.

  // Field positions of the divider staging registers.
  localparam int N_TEST_BIT  = 7;  // Factory test bit in the N stage.
  localparam int R_LSB       = 1;  // pll_ref_div sits in bits 6:1.
  localparam int TRIG_BIT    = 0;  // freq_latch_trigger.

  // Reset values.
  localparam logic [7:0] WATCHDOG_RST = 8'h80;  // Pin acts as powerdown_in at power-up.
  localparam logic [7:0] N_STAGE_RST  = 8'h00;
  localparam logic [7:0] R_STAGE_RST  = 8'h00;
  localparam logic [7:0] SPREAD_RST   = 8'h00;

  // PLL constant used for divider-based programming, the same for every strap.
  localparam logic [31:0] PLL_CONST = 32'd96016000;

  // Timing: clock period, one second, and the reset pulse width.
  localparam longint CLK_PERIOD_NS  = 100;
  localparam longint ONE_SEC_NS     = 1000000000;
  localparam longint RST_PULSE_NS   = 1600;
  localparam int     TICK_CYC       = int'(ONE_SEC_NS / CLK_PERIOD_NS);
  localparam int     RST_PULSE_CYC  = int'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : cgw_pkg

// ### rtl/cgw_wd_if.sv
// Interface that carries control and expiry between the watchdog core and its timer.
`timescale 1ns/1ps
interface cgw_wd_if;
  logic [3:0] tmo_sel;  // Timeout in seconds, zero means off.
  logic       run;      // Timer counts while high.
  logic       restart;  // One-cycle pulse that clears the count.
  logic       expire;   // One-cycle pulse when the timeout is reached.
  modport ctl (output tmo_sel, output run, output restart, input expire);
  modport tmr (input tmo_sel, input run, input restart, output expire);
endinterface : cgw_wd_if

// ### rtl/cgw_sec_timer.sv
// Seconds timer paced by a one-second tick derived from the reference clock.
`timescale 1ns/1ps
module cgw_sec_timer
  import cgw_pkg::*;
#(
  parameter int TICK = cgw_pkg::TICK_CYC  // Clock cycles per second.
)(
  // Clock and reset.
  input  wire logic CLOCK_I,
  input  wire logic NRST_I,
  // Control from the watchdog core.
  cgw_wd_if.tmr     wd
);

  localparam int TW = $clog2(TICK);

  // The divider needs at least two states to form a tick.
  if (TICK < 2) begin : g_bad_tick
    $error("TICK must be at least 2");
  end

  logic [TW-1:0] pre_r;     // Cycles within the current second.
  logic [3:0]    sec_r;     // Whole seconds elapsed.
  logic          expire_r;  // Registered expiry pulse.

  // Decoding of the tick and of the expiry moment.
  wire       clear    = wd.restart | ~wd.run;
  wire       tick     = (pre_r == TW'(TICK - 1));
  wire [3:0] sec_inc  = sec_r + 4'h1;
  wire       hit      = wd.run & tick & (sec_inc >= wd.tmo_sel);

  // Prescaler and seconds counter; an expiry restarts the count at once.
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pre_r    <= '0;
      sec_r    <= 4'h0;
      expire_r <= 1'b0;
    end
    else
    begin
      pre_r    <= (clear | tick) ? '0 : pre_r + TW'(1);
      sec_r    <= (clear | hit) ? 4'h0 : (tick ? sec_inc : sec_r);
      expire_r <= hit & ~wd.restart;
    end
  end

  assign wd.expire = expire_r;

endmodule // cgw_sec_timer

// ### testbench/cgw_pin_model.sv
// Board model of the shared reset or powerdown pin with its pull-up.
`timescale 1ns/1ps
module cgw_pin_model (
  // Device side of the pin.
  input  wire logic oe_i,
  input  wire logic drv_i,
  // Board powerdown switch, high pulls the pin low.
  input  wire logic pd_req_i,
  // Resolved pin level.
  output logic      pin_o
);
  // The pull-up holds the pin high unless a party pulls it low.
  assign pin_o = ((oe_i && !drv_i) || pd_req_i) ? 1'b0 : 1'b1;
endmodule // cgw_pin_model

// ### testbench/tb_clockgen_watchdog_freq_control.sv
// Self-checking bench for the watchdog and frequency control block.
`timescale 1ns/1ps
module tb_clockgen_watchdog_freq_control;
  import cgw_pkg::*;
  localparam int TK = 40;  // A short second keeps the run brief.
  localparam logic [3:0] REV = 4'h2;  // Arbitrary revision code.
  localparam logic [3:0] VEN = 4'h5;  // Arbitrary vendor code.
  logic        clk, nrst, wr, rd, pd_req, pin, oe, drv, pdn, strap, ss_en, ss_mode;
  logic [7:0]  addr, wdat, rdat;
  logic [6:0]  pll_n;
  logic [5:0]  pll_r;
  logic [1:0]  ss_amt;
  logic [31:0] pll_p;
  int          err_count, checks, n;
  cgw_watchdog #(.TICK(TK), .REV_ID(REV), .VENDOR_ID(VEN)) i_cgw_watchdog (
    .CLOCK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdat), .REG_RD_I(rd), .REG_RDATA_O(rdat), .SRST_PIN_I(pin),
    .SRST_PIN_O(drv), .SRST_PIN_OE_O(oe), .POWERDOWN_O(pdn), .PLL_N_O(pll_n),
    .PLL_R_O(pll_r), .USE_STRAP_O(strap), .PLL_P_O(pll_p), .SS_EN_O(ss_en),
    .SS_MODE_O(ss_mode), .SS_AMT_O(ss_amt));
  cgw_pin_model i_cgw_pin_model (.oe_i(oe), .drv_i(drv), .pd_req_i(pd_req), .pin_o(pin));
  // The clock runs at 10 MHz.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compares a value of the design with its expectation.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Compares a measured cycle count with a window.
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One register write; the strobe stands across one rising edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // One register read, compared once the registered data has settled.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(nm, 32'(e), 32'(rdat));
  endtask
  // Waits a bounded time for a reset pulse and checks its width when it comes.
  task automatic wait_pulse(input int lim, output int cnt);
    int w;
    cnt = 0;
    w = 0;
    while (oe !== 1'b1 && cnt < lim)
    begin
      @(negedge clk);
      cnt++;
    end
    if (cnt < lim)
    begin
      chk("pin level", 32'h0, 32'(pin));
      while (oe === 1'b1 && w < 40)
      begin
        w++;
        @(negedge clk);
      end
      chk("pulse width", RST_PULSE_CYC, w);
    end
  endtask
  // Cuts a hung run short; the limit counts as a mismatch.
  initial
  begin
    #5000000;
    err_count++;
    report_and_stop();
  end
  // Main sequence of register transactions.
  initial
  begin
    {nrst, wr, rd, pd_req, addr, wdat, err_count, checks} = '0;
    // Counting rising edges avoids a false falling edge as the clock leaves X.
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rd_chk("watchdog reg", WATCHDOG_CTRL_OFS, WATCHDOG_RST);
    rd_chk("n stage", N_STAGE_OFS, 8'h00);
    rd_chk("r stage", R_STAGE_OFS, 8'h00);
    wr_reg(SIGNATURE_OFS, 8'hff);
    rd_chk("signature", SIGNATURE_OFS, {REV, VEN});
    rd_chk("unmapped", 8'h0f, 8'h00);
    chk("strap at reset", 32'h1, 32'(strap));
    chk("pll constant", PLL_CONST, pll_p);
    pd_req = 1'b1;
    repeat (3) @(negedge clk);
    chk("powerdown", 32'h1, 32'(pdn));
    pd_req = 1'b0;
    // Every spread mode and amount, then spreading off.
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(SPREAD_CTRL_OFS, {4'h8, 1'b0, 3'(i)});
      chk("spread", {28'h0, 1'b1, 3'(i)}, {28'h0, ss_en, ss_mode, ss_amt});
    end
    wr_reg(SPREAD_CTRL_OFS, 8'h00);
    chk("spread off", 32'h0, 32'(ss_en));
    // A rising trigger latches both stages; a steady one does nothing.
    wr_reg(N_STAGE_OFS, 8'h15);
    wr_reg(R_STAGE_OFS, 8'h55);
    wr_reg(R_STAGE_OFS, 8'h00);
    chk("divider pair", 32'h0ad4, {pll_n, pll_r, strap});
    wr_reg(R_STAGE_OFS, 8'h01);
    wr_reg(N_STAGE_OFS, 8'h33);
    wr_reg(R_STAGE_OFS, 8'ha3);
    @(negedge clk);
    chk("steady trigger", 32'h15, 32'(pll_n));
    rd_chk("r reserved", R_STAGE_OFS, 8'h23);
    // One second armed, revert to the strap, repeating expiries.
    wr_reg(WATCHDOG_CTRL_OFS, 8'h01);
    wr_reg(R_STAGE_OFS, 8'h22);
    wr_reg(R_STAGE_OFS, 8'h23);
    // The stored trigger edge reaches the active dividers one cycle later.
    @(negedge clk);
    chk("new pair", 32'h19a2, {pll_n, pll_r, strap});
    wait_pulse(TK + 20, n);
    chk_rng("first expiry", TK - 2, TK + 8, n);
    rd_chk("alarm set", WATCHDOG_CTRL_OFS, 8'h11);
    chk("no revert yet", 32'h0, 32'(strap));
    wait_pulse(TK, n);
    chk_rng("second expiry", TK - 24, TK - 12, n);
    chk("strap revert", 32'h1, 32'(strap));
    wait_pulse(TK, n);
    chk_rng("third expiry", TK - 24, TK - 12, n);
    wr_reg(WATCHDOG_CTRL_OFS, 8'h00);
    rd_chk("alarm clear", WATCHDOG_CTRL_OFS, 8'h00);
    wait_pulse(3 * TK, n);
    chk_rng("stopped", 3 * TK, 3 * TK, n);
    // Clearing the timeout before expiry keeps the new frequency.
    wr_reg(WATCHDOG_CTRL_OFS, 8'h02);
    wr_reg(N_STAGE_OFS, 8'h44);
    wr_reg(R_STAGE_OFS, 8'h22);
    wr_reg(R_STAGE_OFS, 8'h23);
    repeat (TK) @(negedge clk);
    wr_reg(WATCHDOG_CTRL_OFS, 8'h00);
    wait_pulse(3 * TK, n);
    chk_rng("cleared early", 3 * TK, 3 * TK, n);
    chk("kept pair", 32'h2222, {pll_n, pll_r, strap});
    // Three seconds armed with revert to the previous software pair.
    wr_reg(WATCHDOG_CTRL_OFS, 8'h43);
    wr_reg(N_STAGE_OFS, 8'h55);
    wr_reg(R_STAGE_OFS, 8'h22);
    wr_reg(R_STAGE_OFS, 8'h27);
    wait_pulse(3 * TK + 20, n);
    chk_rng("three seconds", 3 * TK - 2, 3 * TK + 8, n);
    wait_pulse(3 * TK, n);
    chk("previous pair", 32'h2222, {pll_n, pll_r, strap});
    // With the pin as powerdown input the reset pulse never leaves.
    wr_reg(WATCHDOG_CTRL_OFS, 8'h81);
    wait_pulse(3 * TK, n);
    chk_rng("pin as input", 3 * TK, 3 * TK, n);
    rd_chk("alarm only", WATCHDOG_CTRL_OFS, 8'h91);
    report_and_stop();
  end
endmodule // tb_clockgen_watchdog_freq_control
